// File: verilog/pps_defines.svh
// constants for the peripheral input pin select block
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// remappable pins and selectors
`define PPS_PIN_COUNT      25
`define PPS_SEL_W          5
`define PPS_SEL_COUNT      18
`define PPS_SEL_RST        5'h1f
`define PPS_PIN_TEN        10

// pins that power up analog (bit per remappable pin)
`define PPS_ANALOG_MASK    25'h0001fff
`define PPS_DIGEN_RST      25'h0000000

// register byte addresses; selector k sits at SEL_BASE + 4*k
`define PPS_ADDR_W         8
`define PPS_SEL_BASE       8'h00
`define PPS_PORT_CTRL      8'h48
`define PPS_ANALOG_CFG     8'h4c
`define PPS_STATUS         8'h50

// selector register byte addresses, in selector order
`define PPS_EXT_IRQ1_PIN_SELECT        8'h00
`define PPS_EXT_IRQ2_PIN_SELECT        8'h04
`define PPS_EXT_IRQ3_PIN_SELECT        8'h08
`define PPS_TIMER0_CLOCK_PIN_SELECT    8'h0c
`define PPS_TIMER3_CLOCK_PIN_SELECT    8'h10
`define PPS_TIMER5_CLOCK_PIN_SELECT    8'h14
`define PPS_CAPTURE1_PIN_SELECT        8'h18
`define PPS_CAPTURE2_PIN_SELECT        8'h1c
`define PPS_CAPTURE3_PIN_SELECT        8'h20
`define PPS_TIMER1_GATE_PIN_SELECT     8'h24
`define PPS_TIMER3_GATE_PIN_SELECT     8'h28
`define PPS_TIMER5_GATE_PIN_SELECT     8'h2c
`define PPS_SERIAL2_RX_PIN_SELECT      8'h30
`define PPS_SERIAL2_CLOCK_PIN_SELECT   8'h34
`define PPS_SPI_B_DATA_IN_PIN_SELECT   8'h38
`define PPS_SPI_B_CLOCK_IN_PIN_SELECT  8'h3c
`define PPS_SPI_B_SELECT_IN_PIN_SELECT 8'h40
`define PPS_PWM_FAULT_PIN_SELECT       8'h44

// port control fields
`define PPS_PC_LATCH       0
`define PPS_PC_DIR         1
`define PPS_PC_PUDIS_N     2
`define PPS_PC_RST         3'h6

// status fields
`define PPS_ST_PIN         0
`define PPS_ST_DEBUG       1
`define PPS_ST_BADSEL      2

`endif

// File: verilog/pps_pkg.sv
// types for the peripheral input pin select block
package pps_pkg;

    // shared pin ten control, laid out as its register
    typedef struct packed {
        logic pullup_disable_n;
        logic direction_bit;
        logic output_latch;
    } pps_pin_ctrl_t;

    // registered answer of the register bus
    typedef struct packed {
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } pps_apb_rsp_t;

endpackage : pps_pkg

// File: verilog/pps_input_select.sv
// peripheral input pin select with shared pin ten control and apb registers
//
// Contract
// (RULE1) each input has 5-bit selector choosing pin
// (RULE2) routing is per peripheral, not per pin
// (RULE3) software writes only supported pin numbers
// (RULE4) selectors for irq, timer clocks, captures, gates
// (RULE5) selectors for serial2, spi b, pwm fault
// (RULE6) direction 0 drives latch; 1 reads, pullup
// (RULE7) as pin ten: 1 remap input, 0 output
// (RULE8) analog pins after reset until enabled digital
// (RULE9) debug enabled disables all other pin functions
// (RULE10) debug carries data both ways, direction ignored
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"

module pps_input_select (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // apb slave
    input  wire logic [`PPS_ADDR_W-1:0]        paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // remappable pins from the pads
    input  wire logic [`PPS_PIN_COUNT-1:0]     rp_pin_in,
    // routed peripheral inputs, in selector order
    output logic      [`PPS_SEL_COUNT-1:0]     periph_in,
    // peripheral output mapped onto pin ten
    input  wire logic                          pin_ten_out_map,
    input  wire logic                          pin_ten_out_data,
    // programming and debug port
    input  wire logic                          debug_en,
    input  wire logic                          dbg_data_drive,
    input  wire logic                          dbg_data_out,
    output logic                               program_debug_data,
    // shared pin ten pad control
    output logic                               shared_pin_o,
    output logic                               shared_pin_oe_n,
    output logic                               shared_pin_pullup
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int NP = `PPS_PIN_COUNT;
    localparam int NS = `PPS_SEL_COUNT;
    localparam int SW = `PPS_SEL_W;

    logic [SW-1:0]           sel_r [NS];
    pps_pkg::pps_pin_ctrl_t  pctl_r;
    logic [NP-1:0]           digen_r;
    logic [NP-1:0]           sync1_r;
    logic [NP-1:0]           sync2_r;
    logic [NP-1:0]           eff_in;
    logic [NS-1:0]           periph_r;
    logic [NS-1:0]           bad_sel;
    pps_pkg::pps_apb_rsp_t   rsp_r;
    pps_pkg::pps_apb_rsp_t   rsp_nxt;
    logic                    pin_o_r;
    logic                    pin_oe_n_r;
    logic                    pullup_r;
    logic                    dbg_data_in_r;
    logic                    acc;
    logic                    wr_done;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // selector slot hit: index in range and aligned within selector window
    function automatic logic sel_hit(input logic [`PPS_ADDR_W-1:0] a);
        logic [`PPS_ADDR_W-1:0] off;
        off = a - `PPS_SEL_BASE;
        sel_hit = (a >= `PPS_SEL_BASE) && (off[1:0] == 2'h0)
                  && (int'(off[`PPS_ADDR_W-1:2]) < NS);
    endfunction : sel_hit

    function automatic int sel_idx(input logic [`PPS_ADDR_W-1:0] a);
        logic [`PPS_ADDR_W-1:0] off;
        off = a - `PPS_SEL_BASE;
        sel_idx = int'(off[`PPS_ADDR_W-1:2]);
    endfunction : sel_idx

    // picks pin n; numbers past the pin count give a quiet low
    function automatic logic pick(input logic [NP-1:0] v,
                                  input logic [SW-1:0] n);
        pick = (int'(n) < NP) ? v[n] : 1'b0;
    endfunction : pick

    ////////////////////////////////////////////////////////////////////////
    // pad input synchronisers

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= rp_pin_in;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective digital pin values

    always_comb begin
        // analog pins read low until software enables their digital buffer
        eff_in = sync2_r & (~`PPS_ANALOG_MASK | digen_r); // RULE8
        // pin ten feeds remapping only as an input and never under debug
        if (!pctl_r.direction_bit || debug_en) begin // RULE7 RULE9
            eff_in[`PPS_PIN_TEN] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-peripheral routing

    // one mux per peripheral input, steered by its own selector
    for (genvar k = 0; k < NS; k++) begin : g_route
        always_ff @(posedge clk) begin
            if (rst) begin
                periph_r[k] <= 1'b0;
            end else begin
                periph_r[k] <= pick(eff_in, sel_r[k]); // RULE1 RULE2 RULE3
            end
        end
        assign bad_sel[k] = (int'(sel_r[k]) >= NP);
    end

    assign periph_in = periph_r;

    ////////////////////////////////////////////////////////////////////////
    // register writes

    assign acc     = psel && penable;
    assign wr_done = acc && rsp_r.ready && pwrite;

    // selectors in table order: irq1-3, t0/t3/t5 clocks, capture1-3,
    // t1/t3/t5 gates, serial2 rx and clock, spi b data/clock/select, fault
    for (genvar k = 0; k < NS; k++) begin : g_sel
        always_ff @(posedge clk) begin
            if (rst) begin
                sel_r[k] <= `PPS_SEL_RST;
            end else if (wr_done && sel_hit(paddr) && sel_idx(paddr) == k) begin
                sel_r[k] <= pwdata[SW-1:0]; // RULE4 RULE5
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pctl_r <= `PPS_PC_RST;
        end else if (wr_done && paddr == `PPS_PORT_CTRL) begin
            pctl_r <= pwdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            digen_r <= `PPS_DIGEN_RST; // RULE8
        end else if (wr_done && paddr == `PPS_ANALOG_CFG) begin
            digen_r <= pwdata[NP-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads and bus answer

    // one wait state: ready rises the cycle after the access phase starts
    always_comb begin
        rsp_nxt = '0;
        if (acc && !rsp_r.ready) begin
            rsp_nxt.ready = 1'b1;
            if (sel_hit(paddr)) begin
                rsp_nxt.rdata[SW-1:0] = sel_r[sel_idx(paddr)];
            end else if (paddr == `PPS_PORT_CTRL) begin
                rsp_nxt.rdata[2:0] = pctl_r;
            end else if (paddr == `PPS_ANALOG_CFG) begin
                rsp_nxt.rdata[NP-1:0] = digen_r;
            end else if (paddr == `PPS_STATUS) begin
                rsp_nxt.rdata[`PPS_ST_PIN]    = sync2_r[`PPS_PIN_TEN];
                rsp_nxt.rdata[`PPS_ST_DEBUG]  = debug_en;
                rsp_nxt.rdata[`PPS_ST_BADSEL] = |bad_sel;
            end else begin
                rsp_nxt.slverr = 1'b1;
            end
            // status is read only; a write there is refused
            if (pwrite && paddr == `PPS_STATUS) begin
                rsp_nxt.slverr = 1'b1;
            end
            if (pwrite) begin
                rsp_nxt.rdata = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign prdata  = rsp_r.rdata;
    assign pready  = rsp_r.ready;
    assign pslverr = rsp_r.slverr;

    ////////////////////////////////////////////////////////////////////////
    // shared pin ten pad control

    // debug owns the pad outright; direction bit is not consulted then
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_o_r    <= 1'b0;
            pin_oe_n_r <= 1'b1;
            pullup_r   <= 1'b0;
        end else if (debug_en) begin
            pin_o_r    <= dbg_data_out; // RULE10
            pin_oe_n_r <= ~dbg_data_drive; // RULE9 RULE10
            pullup_r   <= 1'b0; // RULE9
        end else if (!pctl_r.direction_bit) begin
            pin_o_r    <= pin_ten_out_map ? pin_ten_out_data // RULE7
                                          : pctl_r.output_latch; // RULE6
            pin_oe_n_r <= 1'b0; // RULE6
            pullup_r   <= 1'b0;
        end else begin
            pin_o_r    <= 1'b0;
            pin_oe_n_r <= 1'b1; // RULE6
            pullup_r   <= ~pctl_r.pullup_disable_n; // RULE6
        end
    end

    // debug input path uses the synchronised pad whatever the direction bit
    always_ff @(posedge clk) begin
        if (rst) begin
            dbg_data_in_r <= 1'b0;
        end else begin
            dbg_data_in_r <= debug_en & sync2_r[`PPS_PIN_TEN]; // RULE10
        end
    end

    assign shared_pin_o       = pin_o_r;
    assign shared_pin_oe_n    = pin_oe_n_r;
    assign shared_pin_pullup  = pullup_r;
    assign program_debug_data = dbg_data_in_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wr_sel0;
        psel && penable && pready && pwrite && paddr == `PPS_EXT_IRQ1_PIN_SELECT;
    endsequence

    sequence s_rd_last;
        psel && penable && pready && !pwrite
            && paddr == `PPS_SEL_BASE + 8'(4 * (NS - 1));
    endsequence

    // setup cycle followed by the first access cycle
    sequence s_apb_access;
        psel && !penable ##1 psel && penable;
    endsequence

    sequence s_wr_last;
        psel && penable && pready && pwrite
            && paddr == `PPS_PWM_FAULT_PIN_SELECT;
    endsequence

    sequence s_rd_status;
        $rose(pready) && !pwrite && paddr == `PPS_STATUS;
    endsequence

    a_route_follows: assert property ( // RULE1
        periph_in[0] == $past(pick(eff_in, sel_r[0])))
        else $error("routed input does not follow its selector");

    a_sel_own_write: assert property ( // RULE2
        s_wr_sel0 |=> sel_r[0] == $past(pwdata[SW-1:0])
                      && $stable(sel_r[1]))
        else $error("selector write touched the wrong peripheral");

    a_bad_sel_low: assert property ( // RULE3
        bad_sel[3] |=> !periph_in[3])
        else $error("out of range selection did not read low");

    a_sel_readback: assert property ( // RULE4
        $rose(pready) && !pwrite && paddr == `PPS_SEL_BASE
        |-> prdata == {27'h0, sel_r[0]})
        else $error("irq selector readback wrong");

    a_fault_readback: assert property ( // RULE5
        s_rd_last |-> prdata == {27'h0, sel_r[NS-1]})
        else $error("fault selector readback wrong");

    a_out_drive: assert property ( // RULE6
        !debug_en && !pctl_r.direction_bit && !pin_ten_out_map
        |=> !shared_pin_oe_n && shared_pin_o == $past(pctl_r.output_latch))
        else $error("output mode does not drive the latch");

    a_pin_ten_in: assert property ( // RULE7
        !pctl_r.direction_bit |-> !eff_in[`PPS_PIN_TEN])
        else $error("pin ten feeds inputs while an output");

    a_analog_reset: assert property ( // RULE8
        $fell(rst) |-> digen_r == '0 && eff_in[0] == 1'b0)
        else $error("analog pins not analog after reset");

    a_debug_owns: assert property ( // RULE9
        debug_en [*2] |-> !shared_pin_pullup && !eff_in[`PPS_PIN_TEN])
        else $error("pin function active during debug");

    a_debug_drive: assert property ( // RULE10
        debug_en |=> shared_pin_oe_n == !$past(dbg_data_drive)
                     && shared_pin_o == $past(dbg_data_out))
        else $error("debug data path wrong");

    // a single wait state: the answer comes one cycle into the access phase
    a_one_wait: assert property ( // RULE1
        s_apb_access |=> pready)
        else $error("bus answer not after one wait state");

    a_sel_hold: assert property ( // RULE1
        !(psel && penable && pready && pwrite) |=> $stable(sel_r[0]))
        else $error("selector changed without a completed write");

    a_fault_route: assert property ( // RULE2
        periph_in[NS-1] == $past(pick(eff_in, sel_r[NS-1])))
        else $error("fault input does not follow its own selector");

    a_status_bad: assert property ( // RULE3
        s_rd_status |-> prdata[`PPS_ST_BADSEL] == $past(bad_sel != '0))
        else $error("out of range flag wrong in status");

    a_last_write: assert property ( // RULE5
        s_wr_last |=> sel_r[NS-1] == $past(pwdata[SW-1:0]))
        else $error("fault selector write lost");

    a_ctrl_write: assert property ( // RULE6
        psel && penable && pready && pwrite && paddr == `PPS_PORT_CTRL
        |=> pctl_r == $past(pwdata[2:0]))
        else $error("port control write lost");

    a_input_mode: assert property ( // RULE6
        !debug_en && pctl_r.direction_bit
        |=> shared_pin_oe_n && shared_pin_pullup == !$past(pctl_r.pullup_disable_n))
        else $error("input mode drives the pin or pull-up wrong");

    a_remap_out: assert property ( // RULE7
        !debug_en && !pctl_r.direction_bit && pin_ten_out_map
        |=> !shared_pin_oe_n && shared_pin_o == $past(pin_ten_out_data))
        else $error("mapped output does not reach pin ten");

    a_analog_gate: assert property ( // RULE8
        !digen_r[0] |-> !eff_in[0])
        else $error("analog pin read as digital");

    a_digen_write: assert property ( // RULE8
        psel && penable && pready && pwrite && paddr == `PPS_ANALOG_CFG
        |=> digen_r == $past(pwdata[NP-1:0]))
        else $error("analog configuration write lost");

    a_status_dbg: assert property ( // RULE9
        s_rd_status |-> prdata[`PPS_ST_DEBUG] == $past(debug_en)
                        && prdata[`PPS_ST_PIN] == $past(sync2_r[`PPS_PIN_TEN]))
        else $error("debug or pin bit wrong in status");

    a_debug_quiet: assert property ( // RULE9
        !debug_en |=> !program_debug_data)
        else $error("debug data seen while debug is off");

    a_debug_in: assert property ( // RULE10
        debug_en |=> program_debug_data == $past(sync2_r[`PPS_PIN_TEN]))
        else $error("debug data input path wrong");

endmodule : pps_input_select
`default_nettype wire

// File: tb/pps_pad_model.sv
// pad and pin model standing at the far side of the pin select block
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"
module pps_pad_model (
    // clock
    input  wire logic                      clk,
    // pad drive of shared pin ten
    input  wire logic                      pad_o,
    input  wire logic                      pad_oe_n,
    input  wire logic                      pad_pullup,
    // levels forced from outside
    input  wire logic [`PPS_PIN_COUNT-1:0] ext_lvl,
    input  wire logic                      ext_drv,
    // pin levels seen by the block
    output logic      [`PPS_PIN_COUNT-1:0] pins
);
    logic float_r = 1'b0;
    // an undriven pin wanders so a stale level never looks valid
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        pins = ext_lvl;
        if (!pad_oe_n) begin
            pins[10] = pad_o;
        end else if (ext_drv) begin
            pins[10] = ext_lvl[10];
        end else if (pad_pullup) begin
            pins[10] = 1'b1;
        end else begin
            pins[10] = float_r;
        end
    end
endmodule : pps_pad_model
`default_nettype wire

// File: tb/tb_pps_input_select.sv
// self-checking bench for the peripheral input pin select block
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"
module tb_pps_input_select;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, map = 1'b0, mdat = 1'b0, dbg = 1'b0, pdrv = 1'b0;
    logic        pout = 1'b0, pgdd, po, poe_n, ppu, edrv = 1'b1;
    logic [24:0] elvl = 25'h0, pins;
    logic [17:0] periph_in, e;
    int          errors = 0, num_checks = 0;
    always #5 clk = ~clk;
    pps_input_select i_pps_input_select (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rp_pin_in(pins), .periph_in(periph_in),
        .pin_ten_out_map(map), .pin_ten_out_data(mdat), .debug_en(dbg),
        .dbg_data_drive(pdrv), .dbg_data_out(pout), .program_debug_data(pgdd),
        .shared_pin_o(po),
        .shared_pin_oe_n(poe_n), .shared_pin_pullup(ppu));
    pps_pad_model i_pps_pad_model (.clk(clk), .pad_o(po), .pad_oe_n(poe_n),
        .pad_pullup(ppu), .ext_lvl(elvl), .ext_drv(edrv), .pins(pins));
    ////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // one apb transfer; read data checked under a mask
    task xfer(input string nm, input logic [7:0] a, input logic w, input logic [31:0] d,
              input logic [31:0] x, input logic [31:0] m, input logic xe);
        int n;
        n = 0;
        @(posedge clk);
        paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        chk({nm, " err"}, {31'h0, xe}, {31'h0, pslverr});
        if (!w) chk(nm, x, prdata & m);
        psel <= 1'b0; penable <= 1'b0;
    endtask : xfer
    task settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    function automatic logic [7:0] sa(input int k);
        return `PPS_SEL_BASE + 8'(4 * k);
    endfunction : sa
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle();
        for (int k = 0; k < 18; k++) xfer("sel rst", sa(k), 0, 0, 32'h1f, '1, 0);
        xfer("port rst", `PPS_PORT_CTRL, 0, 0, 32'h6, '1, 0);
        xfer("ana rst", `PPS_ANALOG_CFG, 0, 0, 32'h0, '1, 0);
        xfer("stat rst", `PPS_STATUS, 0, 0, 32'h4, 32'h6, 0);
        chk("pad rst", 32'h2, {29'h0, ppu, poe_n, po});
        chk("route rst", 32'h0, {14'h0, periph_in});
        xfer("unmapped", 8'h7c, 0, 0, 32'h0, 32'h0, 1);
        xfer("stat wr", `PPS_STATUS, 1, 32'h7, 32'h0, 32'h0, 1);
        $display("test reset and refusals done");
        xfer("ana all", `PPS_ANALOG_CFG, 1, 32'h1ffffff, 0, 0, 0);
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 18; k++) xfer("sel", sa(k), 1, s ? 7 + k : k, 0, 0, 0);
            for (int p = 0; p < 2; p++) begin
                @(posedge clk);
                elvl <= p ? 25'h1555555 : 25'h0aaaaaa;
                // odd shift in the second pass flips the parity of every routed pin
                for (int k = 0; k < 18; k++) e[k] = k[0] ^ s[0] ^ p[0];
                settle();
                chk("route", {14'h0, e}, {14'h0, periph_in});
            end
        end
        $display("test routing done");
        xfer("ana off", `PPS_ANALOG_CFG, 1, 32'h0, 0, 0, 0);
        xfer("sel0", sa(0), 1, 32'h5, 0, 0, 0);
        xfer("sel1", sa(1), 1, 32'h14, 0, 0, 0);
        elvl <= '1;
        settle();
        chk("analog", 32'h2, {30'h0, periph_in[1:0]});
        xfer("ana pin5", `PPS_ANALOG_CFG, 1, 32'h20, 0, 0, 0);
        settle();
        chk("digital", 32'h3, {30'h0, periph_in[1:0]});
        xfer("sel field", sa(0), 1, 32'hffffffe3, 0, 0, 0);
        xfer("sel field", sa(0), 0, 0, 32'h3, '1, 0);
        xfer("sel big", sa(0), 1, 32'h19, 0, 0, 0);
        settle();
        chk("big sel", 32'h0, {31'h0, periph_in[0]});
        xfer("stat big", `PPS_STATUS, 0, 0, 32'h4, 32'h4, 0);
        $display("test analog and range done");
        xfer("ana all", `PPS_ANALOG_CFG, 1, 32'h1ffffff, 0, 0, 0);
        xfer("sel ten", sa(0), 1, `PPS_PIN_TEN, 0, 0, 0);
        edrv <= 1'b0;
        xfer("out latch", `PPS_PORT_CTRL, 1, 32'h1, 0, 0, 0);
        settle();
        chk("latch drive", 32'h1, {29'h0, ppu, poe_n, po});
        @(posedge clk);
        map <= 1'b1;
        settle();
        chk("remap out", 32'h0, {29'h0, ppu, poe_n, po});
        xfer("in pullup", `PPS_PORT_CTRL, 1, 32'h2, 0, 0, 0);
        settle();
        chk("pullup", 32'h6, {29'h0, ppu, poe_n, 1'b0});
        chk("remap in", 32'h1, {31'h0, periph_in[0]});
        $display("test shared pin done");
        xfer("out latch", `PPS_PORT_CTRL, 1, 32'h1, 0, 0, 0);
        edrv <= 1'b1;
        dbg <= 1'b1;
        settle();
        chk("dbg no drive", 32'h1, {31'h0, poe_n});
        chk("dbg no route", 32'h0, {31'h0, periph_in[0]});
        chk("dbg data in", 32'h1, {31'h0, pgdd});
        xfer("stat dbg", `PPS_STATUS, 0, 0, 32'h3, 32'h3, 0);
        edrv <= 1'b0;
        pdrv <= 1'b1;
        pout <= 1'b1;
        settle();
        chk("dbg data out", 32'h1, {30'h0, poe_n, po});
        chk("dbg loop", 32'h1, {31'h0, pgdd});
        $display("test debug done");
        report_and_stop();
    end
endmodule : tb_pps_input_select
`default_nettype wire
